// [core/cpaer_pkg.sv]
// Constants and carrier types for the cross-port error notification block.
// Assumes one switch clock and a synchronous active-high port reset.
//
// How it works
// - Each port gathers correctable and uncorrectable errors of all its functions.
// - Gathered bits follow the error condition and are not readable by software.
// - Each gathered bit stands for one specific error type.
// - The own internal error bit follows locally logged internal errors.
// - Internal errors logged from other ports never set the own internal error bit.
// - Other gathered bits follow the matching status bit of any function.
// - Functions absent in the current operating mode contribute nothing.
// - A mask selects which gathered bits may notify other ports.
// - Any unmasked gathered bit notifies every other port, setting its source flag.
// - A port never notifies itself.
// - The remote status holds one flag per switch port, indexed by source.
// - Remote flags report as correctable or uncorrectable, fatal or non-fatal.
// - Internal error logic drives local, remote and internal error status bits.
package cpaer_pkg;

    localparam int NUM_PORTS = 4;
    localparam int NUM_FUNCS = 3;
    localparam int ERR_W     = 32;
    localparam int LOC_W     = 16;
    localparam int PORT_W    = 2;

    // Bit position of the own internal error bit inside the gathered vector.
    localparam int OWN_IE_POS = 22;

    localparam logic [ERR_W-1:0]     MASK_RST   = 32'hffff_ffff;
    localparam logic [NUM_PORTS-1:0] REMOTE_RST = 4'h0;

    // Report class for remote flags.
    typedef enum logic [1:0] {
        CPAER_REP_NONE,
        CPAER_REP_CORR,
        CPAER_REP_NONFATAL,
        CPAER_REP_FATAL
    } cpaer_rep_t;

    // Error status of one function as seen by the gatherer.
    typedef struct packed {
        logic             present;
        logic [ERR_W-1:0] uncorr;
        logic [ERR_W-1:0] corr;
    } cpaer_func_t;

    // Internal error report toward the port's error reporting logic.
    typedef struct packed {
        logic corr;
        logic nonfatal;
        logic fatal;
    } cpaer_report_t;

endpackage : cpaer_pkg

// [core/cpaer_port.sv]
// Per-port gathering of error status and notification of other switch ports.
// Assumes peer ports drive a notify line each, indexed by port number.
`timescale 1ns/1ns
module cpaer_port (
    // Clock and reset.
    input  wire  logic                                      ref_clk,
    input  wire  logic                                      srst,
    // Identity of this port.
    input  wire  logic [cpaer_pkg::PORT_W-1:0]              port_id,
    // Function status from the port's functions.
    input  wire  cpaer_pkg::cpaer_func_t [cpaer_pkg::NUM_FUNCS-1:0] func_status,
    // Local internal error sources and software clear.
    input  wire  logic [cpaer_pkg::LOC_W-1:0]               local_err_set,
    input  wire  logic [cpaer_pkg::LOC_W-1:0]               local_err_clr,
    // Software controls.
    input  wire  logic                                      mask_wr,
    input  wire  logic [cpaer_pkg::ERR_W-1:0]               mask_wdata,
    input  wire  logic [cpaer_pkg::NUM_PORTS-1:0]           remote_clr,
    input  wire  cpaer_pkg::cpaer_rep_t                     remote_rep_sel,
    // Notifications from peers and toward peers.
    input  wire  logic [cpaer_pkg::NUM_PORTS-1:0]           peer_notify,
    output logic                                            notify_out,
    // Status and reporting.
    output logic [cpaer_pkg::ERR_W-1:0]                     port_error_notify_mask,
    output logic [cpaer_pkg::LOC_W-1:0]                     local_internal_error_status,
    output logic [cpaer_pkg::NUM_PORTS-1:0]                 remote_port_error_status,
    output cpaer_pkg::cpaer_report_t                        ie_report
);

    logic [cpaer_pkg::ERR_W-1:0]     gather_ff;
    logic [cpaer_pkg::ERR_W-1:0]     nxt_gather;
    logic [cpaer_pkg::ERR_W-1:0]     mask_ff;
    logic [cpaer_pkg::LOC_W-1:0]     local_ff;
    logic [cpaer_pkg::NUM_PORTS-1:0] remote_ff;
    logic [cpaer_pkg::NUM_PORTS-1:0] peer_in;
    logic                            notify_ff;
    cpaer_pkg::cpaer_report_t        rep_ff;

    // Drops this port's own line from a notify vector.
    function automatic logic [cpaer_pkg::NUM_PORTS-1:0] drop_self(
        input logic [cpaer_pkg::NUM_PORTS-1:0] v,
        input logic [cpaer_pkg::PORT_W-1:0]    id
    );
        logic [cpaer_pkg::NUM_PORTS-1:0] r;
        r = v;
        r[id] = 1'b0;
        return r;
    endfunction : drop_self

    // The gathered vector is combinational over the function status, one bit per error type.
    always_comb begin
        nxt_gather = '0;
        for (int f = 0; f < cpaer_pkg::NUM_FUNCS; f++) begin
            if (func_status[f].present) begin
                nxt_gather = nxt_gather | func_status[f].uncorr | func_status[f].corr;
            end
        end
        // Only locally logged internal errors drive the own internal error bit.
        nxt_gather[cpaer_pkg::OWN_IE_POS] = |local_ff;
    end

    // The gathered vector is transient and follows its sources each cycle.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gather_ff <= '0;
        end else begin
            gather_ff <= nxt_gather;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mask_ff <= cpaer_pkg::MASK_RST;
        end else if (mask_wr) begin
            mask_ff <= mask_wdata;
        end
    end

    // A set bit in the mask blocks that error from notifying.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            notify_ff <= 1'b0;
        end else begin
            notify_ff <= |(gather_ff & ~mask_ff);
        end
    end

    // Sticky local status; a new error wins over a clear in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            local_ff <= '0;
        end else begin
            local_ff <= (local_ff & ~local_err_clr) | local_err_set;
        end
    end

    assign peer_in = drop_self(peer_notify, port_id);

    // Remote flags are sticky per source port; set wins over clear.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            remote_ff <= cpaer_pkg::REMOTE_RST;
        end else begin
            remote_ff <= (remote_ff & ~remote_clr) | peer_in;
        end
    end

    // Any remote flag is reported in the selected class.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rep_ff <= '0;
        end else begin
            rep_ff <= '0;
            case (remote_rep_sel)
                cpaer_pkg::CPAER_REP_CORR:     rep_ff.corr     <= |remote_ff;
                cpaer_pkg::CPAER_REP_NONFATAL: rep_ff.nonfatal <= |remote_ff;
                cpaer_pkg::CPAER_REP_FATAL:    rep_ff.fatal    <= |remote_ff;
                cpaer_pkg::CPAER_REP_NONE:     rep_ff          <= '0;
                default:                       rep_ff          <= '0;
            endcase
        end
    end

    assign notify_out                  = notify_ff;
    assign port_error_notify_mask      = mask_ff;
    assign local_internal_error_status = local_ff;
    assign remote_port_error_status    = remote_ff;
    assign ie_report                   = rep_ff;

    // Unmasked gathered error raises notify on the next edge.
    notify_follow_a: assert property (@(posedge ref_clk) disable iff (srst)
        $past(!srst) |-> (notify_out == |($past(gather_ff) & ~$past(mask_ff))))
        else $error("notify does not follow unmasked gathered errors");

    // Own notify never sets own remote flag.
    no_self_a: assert property (@(posedge ref_clk) disable iff (srst)
        (!remote_ff[port_id]) |=> !remote_ff[port_id])
        else $error("port flagged itself");

    // Peer notify sets its flag next cycle.
    remote_set_a: assert property (@(posedge ref_clk) disable iff (srst)
        peer_in[0] |=> remote_ff[0])
        else $error("remote flag not set by peer notify");

    // Flag stays until cleared.
    remote_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
        (remote_ff[1] && !remote_clr[1]) |=> remote_ff[1])
        else $error("remote flag dropped without clear");

    // Absent function contributes nothing.
    absent_func_a: assert property (@(posedge ref_clk) disable iff (srst)
        (!func_status[0].present && !func_status[1].present && !func_status[2].present
         && local_ff == '0) |=> (gather_ff == '0))
        else $error("absent function set gathered bits");

    // Own internal bit tracks local status only.
    own_ie_a: assert property (@(posedge ref_clk) disable iff (srst)
        1'b1 |=> gather_ff[cpaer_pkg::OWN_IE_POS] == $past(|local_ff))
        else $error("own internal error bit mismatch");

    // Local set wins over clear.
    local_set_a: assert property (@(posedge ref_clk) disable iff (srst)
        local_err_set[0] |=> local_ff[0])
        else $error("local internal error lost");

    // Report follows selected class.
    report_class_a: assert property (@(posedge ref_clk) disable iff (srst)
        (remote_rep_sel == cpaer_pkg::CPAER_REP_FATAL && |remote_ff) |=> ie_report.fatal)
        else $error("fatal report missing");

    // Mask write lands next cycle.
    mask_write_a: assert property (@(posedge ref_clk) disable iff (srst)
        mask_wr |=> port_error_notify_mask == $past(mask_wdata))
        else $error("mask write lost");

    // Peer notify on line one sets its flag next cycle.
    remote_set1_a: assert property (@(posedge ref_clk) disable iff (srst)
        peer_in[1] |=> remote_ff[1])
        else $error("remote flag one not set by peer notify");

    // Peer notify on line two sets its flag next cycle.
    remote_set2_a: assert property (@(posedge ref_clk) disable iff (srst)
        peer_in[2] |=> remote_ff[2])
        else $error("remote flag two not set by peer notify");

    // Peer notify on line three sets its flag next cycle.
    remote_set3_a: assert property (@(posedge ref_clk) disable iff (srst)
        peer_in[3] |=> remote_ff[3])
        else $error("remote flag three not set by peer notify");

    // Flag zero stays until cleared.
    remote_hold0_a: assert property (@(posedge ref_clk) disable iff (srst)
        (remote_ff[0] && !remote_clr[0]) |=> remote_ff[0])
        else $error("remote flag zero dropped without clear");

    // Flag two stays until cleared.
    remote_hold2_a: assert property (@(posedge ref_clk) disable iff (srst)
        (remote_ff[2] && !remote_clr[2]) |=> remote_ff[2])
        else $error("remote flag two dropped without clear");

    // Flag three stays until cleared.
    remote_hold3_a: assert property (@(posedge ref_clk) disable iff (srst)
        (remote_ff[3] && !remote_clr[3]) |=> remote_ff[3])
        else $error("remote flag three dropped without clear");

    // A clear with no new notify drops the flag.
    remote_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
        (remote_clr[1] && !peer_in[1]) |=> !remote_ff[1])
        else $error("remote flag not cleared");

    // The mask comes out of reset with every bit blocking.
    mask_reset_a: assert property (@(posedge ref_clk) disable iff (srst)
        $past(srst) |-> (mask_ff == cpaer_pkg::MASK_RST))
        else $error("mask reset value wrong");

    // Notify is low right after reset.
    notify_reset_a: assert property (@(posedge ref_clk) disable iff (srst)
        $past(srst) |-> !notify_out)
        else $error("notify high after reset");

    // A fully blocking mask keeps notify low.
    masked_quiet_a: assert property (@(posedge ref_clk) disable iff (srst)
        (&mask_ff) |=> !notify_out)
        else $error("masked error notified");

    // Any unmasked gathered bit raises notify.
    notify_rise_a: assert property (@(posedge ref_clk) disable iff (srst)
        (|(gather_ff & ~mask_ff)) |=> notify_out)
        else $error("unmasked error not notified");

    // An uncorrectable bit of a present function reaches the gathered vector.
    gather_bit_a: assert property (@(posedge ref_clk) disable iff (srst)
        (func_status[0].present && func_status[0].uncorr[0]) |=> gather_ff[0])
        else $error("uncorrectable error not gathered");

    // A correctable bit of a present function reaches the gathered vector.
    corr_bit_a: assert property (@(posedge ref_clk) disable iff (srst)
        (func_status[2].present && func_status[2].corr[5]) |=> gather_ff[5])
        else $error("correctable error not gathered");

    // Gathered bits fall once their sources are gone.
    gather_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
        (nxt_gather == '0) |=> (gather_ff == '0))
        else $error("gathered bit outlived its source");

    // Correctable class reports any flag.
    report_corr_a: assert property (@(posedge ref_clk) disable iff (srst)
        (remote_rep_sel == cpaer_pkg::CPAER_REP_CORR && |remote_ff) |=> ie_report.corr)
        else $error("correctable report missing");

    // Non-fatal class reports any flag.
    report_nonfatal_a: assert property (@(posedge ref_clk) disable iff (srst)
        (remote_rep_sel == cpaer_pkg::CPAER_REP_NONFATAL && |remote_ff)
        |=> ie_report.nonfatal)
        else $error("non-fatal report missing");

    // No class selected means no report.
    report_none_a: assert property (@(posedge ref_clk) disable iff (srst)
        (remote_rep_sel == cpaer_pkg::CPAER_REP_NONE) |=> (ie_report == '0))
        else $error("report raised with no class selected");

    // No flag means no report.
    report_quiet_a: assert property (@(posedge ref_clk) disable iff (srst)
        (remote_ff == '0) |=> (ie_report == '0))
        else $error("report raised with no flag");

    // A clear with no new event drops the local bit.
    local_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
        (local_err_clr[0] && !local_err_set[0]) |=> !local_ff[0])
        else $error("local status not cleared");

    // A local bit stays until cleared.
    local_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
        (local_ff[3] && !local_err_clr[3]) |=> local_ff[3])
        else $error("local status dropped without clear");

    // Remote flags alone never raise the own internal error bit.
    own_ie_quiet_a: assert property (@(posedge ref_clk) disable iff (srst)
        (local_ff == '0) |=> !gather_ff[cpaer_pkg::OWN_IE_POS])
        else $error("own internal error bit set without local error");

endmodule : cpaer_port

// [test/cpaer_peer.sv]
// Model of the peer ports that share notify lines with one port.
// Assumes the bench says which peers raise their notify line.
`timescale 1ns/1ns
module cpaer_peer (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // Peer control and the port's own notify.
    input  wire logic [3:0] fire,
    input  wire logic       notify_in,
    output logic [3:0]      peer_notify,
    output logic            heard_ff
);
    assign peer_notify = fire;
    // Records that the port under test has notified its peers.
    always_ff @(posedge ref_clk) begin
        if (srst) heard_ff <= 1'b0;
        else if (notify_in) heard_ff <= 1'b1;
    end
endmodule : cpaer_peer

// [test/cpaer_port_test.sv]
// Self-checking bench for one port's cross-port error notification.
// Assumes the peer model drives the notify lines of the other ports.
`timescale 1ns/1ns
module cpaer_port_test;
    logic                         ref_clk = 1'b0, srst = 1'b1, mask_wr = 1'b0;
    logic [1:0]                   port_id = 2'h0;
    cpaer_pkg::cpaer_func_t [2:0] func_status = '0;
    logic [15:0]                  local_err_set = '0, local_err_clr = '0, loc_st;
    logic [31:0]                  mask_wdata = '0, rnd = 32'h15, mask;
    logic [3:0]                   remote_clr = '0, fire = '0, peer_notify, rem_st;
    cpaer_pkg::cpaer_rep_t        remote_rep_sel = cpaer_pkg::CPAER_REP_NONE;
    cpaer_pkg::cpaer_report_t     ie_report;
    logic                         notify_out, heard;
    int                           err_count = 0, n_checks = 0;

    cpaer_port u_dut (.ref_clk, .srst, .port_id, .func_status, .local_err_set,
        .local_err_clr, .mask_wr, .mask_wdata, .remote_clr, .remote_rep_sel,
        .peer_notify, .notify_out, .port_error_notify_mask(mask),
        .local_internal_error_status(loc_st), .remote_port_error_status(rem_st),
        .ie_report);
    cpaer_peer u_peer (.ref_clk, .srst, .fire, .notify_in(notify_out), .peer_notify,
        .heard_ff(heard));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] gather(input cpaer_pkg::cpaer_func_t [2:0] f);
        logic [31:0] g;
        g = '0;
        for (int i = 0; i < 3; i++) if (f[i].present) g |= f[i].uncorr | f[i].corr;
        return g;
    endfunction : gather
    function automatic cpaer_pkg::cpaer_report_t rep(input cpaer_pkg::cpaer_rep_t s);
        return {s == cpaer_pkg::CPAER_REP_CORR, s == cpaer_pkg::CPAER_REP_NONFATAL,
                s == cpaer_pkg::CPAER_REP_FATAL};
    endfunction : rep
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    task automatic wr_mask(input logic [31:0] m);
        mask_wdata = m;
        mask_wr = 1'b1;
        tick(1);
        mask_wr = 1'b0;
    endtask : wr_mask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict

    initial forever #25 ref_clk = ~ref_clk;
    initial begin
        #1000000;
        err_count++;
        give_verdict();
    end
    initial begin
        tick(8);
        srst = 1'b0;
        chk(mask, 32'hffffffff);
        chk({loc_st, rem_st, notify_out}, '0);
        // Sparse error bits against an all-blocking, an all-open, then one-open-bit masks keep each compare sharp.
        for (int k = 0; k < 40; k++) begin
            for (int i = 0; i < 3; i++) begin
                rnd = lfsr(rnd);
                func_status[i].present = rnd[0];
                func_status[i].uncorr = ({31'h0, rnd[1]} << rnd[6:2]) & ~32'h40_0000;
                func_status[i].corr = ({31'h0, rnd[7]} << rnd[12:8]) & ~32'h40_0000;
            end
            rnd = lfsr(rnd);
            wr_mask(k == 0 ? '1 : k == 1 ? '0 : ~(32'h1 << rnd[4:0]));
            tick(2);
            chk(mask, mask_wdata);
            chk(notify_out, |(gather(func_status) & ~mask_wdata));
        end
        func_status = '0;
        wr_mask(~32'h40_0000);
        tick(3);
        chk(notify_out, 1'b0);
        rnd = lfsr(rnd);
        local_err_set = 16'h1 << rnd[3:0];
        tick(1);
        local_err_set = '0;
        chk(loc_st, 16'h1 << rnd[3:0]);
        tick(1);
        chk(notify_out, 1'b0);
        tick(1);
        chk(notify_out, 1'b1);
        local_err_clr = '1;
        tick(1);
        local_err_clr = '0;
        tick(2);
        chk({loc_st, notify_out}, '0);
        // A second port number makes peer line zero a real source.
        for (int q = 0; q < 2; q++) begin
        port_id = (q == 0) ? 2'h0 : 2'h2;
        for (int p = 0; p < 4; p++) begin
            remote_rep_sel = cpaer_pkg::cpaer_rep_t'(p);
            fire = 4'h1 << p;
            tick(1);
            fire = '0;
            chk(rem_st, p == port_id ? 4'h0 : 4'h1 << p);
            tick(1);
            chk(ie_report, p == port_id ? '0 : rep(remote_rep_sel));
            tick(2);
            chk(rem_st, p == port_id ? 4'h0 : 4'h1 << p);
            chk(notify_out, 1'b0);
            remote_clr = 4'hf;
            tick(1);
            remote_clr = '0;
            tick(1);
            chk({rem_st, ie_report}, '0);
        end
        end
        chk(heard, 1'b1);
        give_verdict();
    end
endmodule : cpaer_port_test
